// >>> hw/ras_remap_abort.sv
`default_nettype none

module ras_remap_abort (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Register port
  input wire logic [6:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  // System bus access, one cycle per transfer
  input wire logic i_bus_valid,
  input wire logic i_bus_is_dma,
  input wire logic [31:0] i_bus_addr,
  input wire logic [1:0] i_bus_size,
  input wire logic [1:0] i_bus_kind,
  // Decode result and abort to all masters
  output logic [1:0] o_mem_sel,
  output logic o_access_ok,
  output logic o_abort,
  // Remap state
  output logic o_remap_active
);

  typedef struct packed {
    logic remap;
    logic [31:0] rdata;
    logic [1:0] sel;
    logic ok;
    logic abort;
    logic undef_hit;
    logic misal_hit;
    logic [1:0] size;
    logic [1:0] kind;
    logic dma_src;
    logic cpu_src;
    logic dma_seen;
    logic cpu_seen;
    logic [31:0] abort_addr;
  } ras_state_t;

  ras_state_t s_q;
  ras_state_t s_d;

  // ---------------------------------------------------------------
  // Address decode helpers
  // ---------------------------------------------------------------
  function automatic logic addr_undefined(input logic [31:0] a);
    logic [7:0] mb;
    mb = a[27:20];
    if (a[31:28] == ras_pkg::AREA_PERIPH) begin
      addr_undefined = 1'b0;
    end else if (a[31:28] != ras_pkg::AREA_INTERNAL) begin
      addr_undefined = 1'b1;
    end else if (mb == ras_pkg::MB_AREA_ZERO || mb == ras_pkg::MB_FLASH ||
                 mb == ras_pkg::MB_SRAM || mb == ras_pkg::MB_NO_ABORT) begin
      addr_undefined = 1'b0;
    end else begin
      addr_undefined = 1'b1;
    end
  endfunction : addr_undefined

  function automatic logic addr_misaligned(input logic [1:0] sz,
                                           input logic [1:0] lo);
    if (sz == ras_pkg::SZ_WORD) begin
      addr_misaligned = (lo != 2'h0);
    end else if (sz == ras_pkg::SZ_HALF) begin
      addr_misaligned = lo[0];
    end else begin
      addr_misaligned = 1'b0;
    end
  endfunction : addr_misaligned

  function automatic logic [1:0] target(input logic [31:0] a,
                                        input logic rmp);
    if (a[31:28] == ras_pkg::AREA_PERIPH) begin
      target = ras_pkg::SEL_PERIPH;
    end else if (a[27:20] == ras_pkg::MB_AREA_ZERO) begin
      target = rmp ? ras_pkg::SEL_SRAM : ras_pkg::SEL_FLASH;
    end else if (a[27:20] == ras_pkg::MB_FLASH) begin
      target = ras_pkg::SEL_FLASH;
    end else if (a[27:20] == ras_pkg::MB_SRAM) begin
      target = ras_pkg::SEL_SRAM;
    end else begin
      target = ras_pkg::SEL_NONE;
    end
  endfunction : target

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic undef;
    logic misal;
    logic hit;
    undef = 1'b0;
    misal = 1'b0;
    hit = 1'b0;
    s_d = s_q;
    s_d.rdata = 32'h0000_0000;
    s_d.abort = 1'b0;
    s_d.ok = 1'b0;
    s_d.sel = ras_pkg::SEL_NONE;

    // Register writes; only remap control takes effect
    if (i_reg_wr && i_reg_addr == ras_pkg::OFS_REMAP_CONTROL) begin
      if (i_reg_wdata[ras_pkg::REMAP_TOGGLE_BIT]) begin
        s_d.remap = ~s_q.remap;
      end
    end

    // Register reads; reserved and write-only offsets read zero
    if (i_reg_rd) begin
      if (i_reg_addr == ras_pkg::OFS_ABORT_STATUS) begin
        s_d.rdata[ras_pkg::UNDEF_HIT_POS] = s_q.undef_hit;
        s_d.rdata[ras_pkg::MISALIGN_HIT_POS] = s_q.misal_hit;
        s_d.rdata[ras_pkg::SIZE_POS +: 2] = s_q.size;
        s_d.rdata[ras_pkg::KIND_POS +: 2] = s_q.kind;
        s_d.rdata[ras_pkg::DMA_SRC_POS] = s_q.dma_src;
        s_d.rdata[ras_pkg::CPU_SRC_POS] = s_q.cpu_src;
        s_d.rdata[ras_pkg::DMA_SEEN_POS] = s_q.dma_seen;
        s_d.rdata[ras_pkg::CPU_SEEN_POS] = s_q.cpu_seen;
        s_d.dma_seen = 1'b0;
        s_d.cpu_seen = 1'b0;
      end else if (i_reg_addr == ras_pkg::OFS_ABORT_ADDRESS) begin
        s_d.rdata = s_q.abort_addr;
      end else begin
        s_d.rdata = 32'h0000_0000;
      end
    end

    // Bus access check
    if (i_bus_valid) begin
      undef = addr_undefined(i_bus_addr);
      misal = addr_misaligned(i_bus_size, i_bus_addr[1:0]) &&
              !(!i_bus_is_dma && i_bus_kind == ras_pkg::KIND_FETCH);
      hit = undef || misal;
      if (hit) begin
        s_d.abort = 1'b1;
        s_d.abort_addr = i_bus_addr;
        s_d.undef_hit = undef;
        s_d.misal_hit = misal;
        s_d.size = i_bus_size;
        s_d.kind = i_bus_kind;
        s_d.dma_src = i_bus_is_dma;
        s_d.cpu_src = !i_bus_is_dma;
        // Previous abort moves out of source bits into saved bits
        if (s_q.dma_src) begin
          s_d.dma_seen = 1'b1;
        end
        if (s_q.cpu_src) begin
          s_d.cpu_seen = 1'b1;
        end
      end else begin
        s_d.ok = 1'b1;
        s_d.sel = target(i_bus_addr, s_q.remap);
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_reg_rdata = s_q.rdata;
  assign o_mem_sel = s_q.sel;
  assign o_access_ok = s_q.ok;
  assign o_abort = s_q.abort;
  assign o_remap_active = s_q.remap;

endmodule : ras_remap_abort

`default_nettype wire

// >>> hw/ras_pkg.sv
// Notes on behaviour
// - With remap active, area zero vectors 0x0 to 0x20 are served by SRAM.
// - Writing 1 to the remap toggle bit flips remap; writing 0 does nothing.
// - Control 0x00 write-only, status 0x04, address 0x08, 0x0C-0x5C reserved.
// - Any master access to an undefined address gets an abort.
// - An abort is signalled to every master at once.
// - Misaligned word or half-word access is cancelled and aborted.
// - Alignment is checked for all masters except processor instruction fetches.
// - Each abort captures the full aborted address, replacing the old one.
// - For processor data aborts the data address itself is captured.
// - Size field: 00 byte, 01 half-word, 10 word; 11 reserved.
// - Kind field: 00 data read, 01 data write, 10 code fetch; 11 reserved.
// - Bit 0 set exactly when the last abort hit an undefined address.
// - Bit 1 set exactly when the last abort was a misalignment.
// - Bit 16 marks DMA, bit 17 marks processor as last abort source.
// - Bits 24/25 record, per master, an abort overwritten by a later one since last status read.
// - Abort status and abort address read zero after reset.
// - Without remap, area zero maps flash; SRAM stays at its own base.
// - The fourteen regions between memory and peripherals are undefined.
`default_nettype none

package ras_pkg;
  localparam logic [6:0] OFS_REMAP_CONTROL = 7'h00;
  localparam logic [6:0] OFS_ABORT_STATUS = 7'h04;
  localparam logic [6:0] OFS_ABORT_ADDRESS = 7'h08;
  localparam logic [6:0] OFS_RSVD_LAST = 7'h5C;
  localparam int REMAP_TOGGLE_BIT = 0;
  localparam int UNDEF_HIT_POS = 0;
  localparam int MISALIGN_HIT_POS = 1;
  localparam int SIZE_POS = 8;
  localparam int KIND_POS = 10;
  localparam int DMA_SRC_POS = 16;
  localparam int CPU_SRC_POS = 17;
  localparam int DMA_SEEN_POS = 24;
  localparam int CPU_SEEN_POS = 25;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] ADDRESS_RESET = 32'h0000_0000;
  localparam logic [3:0] AREA_INTERNAL = 4'h0;
  localparam logic [3:0] AREA_PERIPH = 4'hF;
  localparam logic [7:0] MB_AREA_ZERO = 8'h00;
  // 1-Mbyte slot numbers within the internal area, address bits 27:20
  localparam logic [7:0] MB_FLASH = 8'h01;
  localparam logic [7:0] MB_SRAM = 8'h02;
  localparam logic [7:0] MB_NO_ABORT = 8'h03;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] KIND_READ = 2'h0;
  localparam logic [1:0] KIND_WRITE = 2'h1;
  localparam logic [1:0] KIND_FETCH = 2'h2;
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_FLASH = 2'h1;
  localparam logic [1:0] SEL_SRAM = 2'h2;
  localparam logic [1:0] SEL_PERIPH = 2'h3;
endpackage : ras_pkg

`default_nettype wire

// >>> test/ras_remap_abort_monitor.sv
`default_nettype none
module ras_remap_abort_monitor (
  input wire logic i_ref_clk, i_reset, i_reg_wr, i_reg_rd, i_bus_valid,
  input wire logic i_bus_is_dma, o_access_ok, o_abort, o_remap_active,
  input wire logic [6:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata, o_reg_rdata, i_bus_addr,
  input wire logic [1:0] i_bus_size, i_bus_kind, o_mem_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);
  sequence s_flip;
    i_reg_wr && i_reg_addr == 7'h00 && i_reg_wdata[0];
  endsequence
  sequence s_misal;
    i_bus_valid && (i_bus_is_dma || i_bus_kind != 2'h2) &&
    (i_bus_size == 2'h2 && i_bus_addr[1:0] != 2'h0 ||
    i_bus_size == 2'h1 && i_bus_addr[0]);
  endsequence
  chk_undef_area:
    assert property (i_bus_valid && i_bus_addr[31:28] inside {[4'h1:4'hE]}
    |=> o_abort) else $error("undefined area passed");
  chk_misal_abort:
    assert property (s_misal |=> o_abort) else $error("misalignment passed");
  chk_fetch_free:
    assert property (i_bus_valid && !i_bus_is_dma && i_bus_kind == 2'h2 &&
    i_bus_addr[31:20] == 12'h000 |=> o_access_ok) else $error("fetch held");
  chk_idle_quiet:
    assert property (!i_bus_valid |=> !o_abort && !o_access_ok)
    else $error("answer without access");
  chk_rdata_idle:
    assert property (!i_reg_rd |=> o_reg_rdata == 32'h0)
    else $error("read data outside slot");
  chk_remap_flip:
    assert property (s_flip |=> o_remap_active != $past(o_remap_active))
    else $error("remap not toggled");
  chk_zero_hold:
    assert property (i_reg_wr && !i_reg_wdata[0] |=> $stable(o_remap_active))
    else $error("remap moved");
  chk_area_zero:
    assert property (i_bus_valid && !i_reg_wr && i_bus_size == 2'h0 &&
    i_bus_addr[31:20] == 12'h000 |=>
    o_mem_sel == (o_remap_active ? 2'h2 : 2'h1)) else $error("area zero map");
endmodule : ras_remap_abort_monitor
bind ras_remap_abort ras_remap_abort_monitor i_mon (
  .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd), .i_bus_valid(i_bus_valid),
  .i_bus_is_dma(i_bus_is_dma), .o_access_ok(o_access_ok),
  .o_abort(o_abort), .o_remap_active(o_remap_active),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .o_reg_rdata(o_reg_rdata), .i_bus_addr(i_bus_addr),
  .i_bus_size(i_bus_size), .i_bus_kind(i_bus_kind), .o_mem_sel(o_mem_sel));
`default_nettype wire

// >>> test/ras_master_model.sv
`default_nettype none
module ras_master_model (
  input wire logic i_ref_clk,
  input wire logic i_abort,
  output logic o_valid, o_is_dma, o_cpu_took,
  output logic [31:0] o_addr,
  output logic [1:0] o_size, o_kind
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {o_valid, o_is_dma, o_cpu_took, o_addr, o_size, o_kind} = '0;
  // One-cycle access; the address is inverted once released
  task automatic issue(input logic d, input logic [31:0] a,
                       input logic [1:0] s, input logic [1:0] k);
    @(posedge i_ref_clk);
    {o_valid, o_is_dma, o_addr, o_size, o_kind} <= {1'b1, d, a, s, k};
    @(posedge i_ref_clk);
    o_valid <= 1'b0;
    o_addr <= ~a;
    #1;
    o_cpu_took = i_abort && !d;
  endtask : issue
endmodule : ras_master_model
`default_nettype wire

// >>> test/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [6:0] i_reg_addr = 7'h00;
  logic [31:0] i_reg_wdata = 32'h0;
  logic [31:0] o_reg_rdata, i_bus_addr;
  logic [1:0] i_bus_size, i_bus_kind, o_mem_sel;
  logic i_bus_valid, i_bus_is_dma, o_access_ok, o_abort, o_remap_active;
  logic took;
  int fail_count = 0;
  int tests_run = 0;
  always #4 i_ref_clk = ~i_ref_clk;
  ras_remap_abort i_dut (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_bus_valid(i_bus_valid),
    .i_bus_is_dma(i_bus_is_dma), .i_bus_addr(i_bus_addr),
    .i_bus_size(i_bus_size), .i_bus_kind(i_bus_kind),
    .o_mem_sel(o_mem_sel), .o_access_ok(o_access_ok), .o_abort(o_abort),
    .o_remap_active(o_remap_active));
  ras_master_model i_mst (.i_ref_clk(i_ref_clk), .i_abort(o_abort),
    .o_valid(i_bus_valid), .o_is_dma(i_bus_is_dma), .o_cpu_took(took),
    .o_addr(i_bus_addr), .o_size(i_bus_size), .o_kind(i_bus_kind));
  task automatic print_verdict;
    if (fail_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  task automatic cmp(input string n, input logic [31:0] e, s);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : cmp
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    {i_reg_wr, i_reg_addr, i_reg_wdata} <= {1'b1, a, d};
    @(posedge i_ref_clk);
    i_reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [31:0] e);
    @(posedge i_ref_clk);
    {i_reg_rd, i_reg_addr} <= {1'b1, a};
    @(posedge i_ref_clk);
    i_reg_rd <= 1'b0;
    #1;
    cmp("rdata", e, o_reg_rdata);
  endtask : rd
  // Expected select of zero means an abort is expected
  task automatic acc(input logic d, input logic [31:0] a,
                     input logic [1:0] s, k, e);
    i_mst.issue(d, a, s, k);
    cmp("abort", 32'(e == 2'h0), 32'(o_abort));
    cmp("access_ok", 32'(e != 2'h0), 32'(o_access_ok));
    cmp("mem_sel", 32'(e), 32'(o_mem_sel));
  endtask : acc
  task automatic t_remap;
    acc(1'b0, 32'h0, 2'h0, 2'h2, 2'h1);
    wr(7'h00, 32'h1);
    #1 cmp("remap", 32'h1, 32'(o_remap_active));
    acc(1'b0, 32'h4, 2'h2, 2'h0, 2'h2);
    wr(7'h00, 32'hFFFFFFFE);
    #1 cmp("remap", 32'h1, 32'(o_remap_active));
    acc(1'b1, 32'h1C, 2'h2, 2'h1, 2'h2);
    acc(1'b1, 32'h00200000, 2'h0, 2'h0, 2'h2);
    wr(7'h00, 32'h1);
    #1 cmp("remap", 32'h0, 32'(o_remap_active));
    acc(1'b0, 32'h0, 2'h0, 2'h2, 2'h1);
    acc(1'b0, 32'hFFFFF000, 2'h2, 2'h0, 2'h3);
    i_mst.issue(1'b1, 32'h00300000, 2'h2, 2'h1);
    cmp("abort", 32'h0, 32'(o_abort));
    cmp("access_ok", 32'h1, 32'(o_access_ok));
    cmp("mem_sel", 32'h0, 32'(o_mem_sel));
  endtask : t_remap
  task automatic t_undef;
    acc(1'b1, 32'h10000000, 2'h2, 2'h0, 2'h0);
    cmp("cpu_took", 32'h0, 32'(took));
    acc(1'b1, 32'hEFFFFFFC, 2'h2, 2'h1, 2'h0);
    rd(7'h04, 32'h01010601);
    rd(7'h08, 32'hEFFFFFFC);
    rd(7'h04, 32'h00010601);
  endtask : t_undef
  task automatic t_misal;
    acc(1'b0, 32'h00200001, 2'h1, 2'h1, 2'h0);
    cmp("cpu_took", 32'h1, 32'(took));
    rd(7'h04, 32'h01020502);
    rd(7'h08, 32'h00200001);
    acc(1'b0, 32'h1, 2'h2, 2'h2, 2'h1);
    acc(1'b1, 32'h00200003, 2'h0, 2'h0, 2'h2);
    acc(1'b1, 32'h2, 2'h2, 2'h2, 2'h0);
    wr(7'h04, 32'hFFFFFFFF);
    wr(7'h08, 32'h0);
    rd(7'h04, 32'h02010A02);
    rd(7'h08, 32'h2);
    acc(1'b0, 32'h00400000, 2'h0, 2'h0, 2'h0);
    rd(7'h04, 32'h01020001);
    rd(7'h08, 32'h00400000);
  endtask : t_misal
  initial begin
    repeat (5) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    rd(7'h04, 32'h0);
    rd(7'h08, 32'h0);
    rd(7'h5C, 32'h0);
    t_remap();
    t_undef();
    t_misal();
    print_verdict();
  end
  initial begin
    repeat (2000) @(posedge i_ref_clk);
    fail_count++;
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
